//--- design/tcn_timer.sv
// Operation
// - asynchronous mode keeps counting during sleep, per tick or prescale multiple.
// - count rollover sets the overflow flag.
// - enabled overflow flag raises an interrupt request that can wake the core.
// - compare mode code 1011 match pulse resets the counter to zero.
// - trigger reset never sets the overflow flag.
// - software write to a count byte wins over a same-cycle trigger reset.
// - compare value pair acts as period while trigger resets are active.
// - count bytes are untouched by any reset; only the trigger clears them.
// - control register loads 00h on power-on or brown-out reset only.
// - writing either count byte clears the prescaler count.
// - count is visible as separate low and high byte registers.
// - control value 30h gives internal clock, 1:8 prescale, stopped.
// - control value 32h gives synchronized external clock, 1:8, stopped.
// - control value 3Eh gives oscillator clock, asynchronous, 1:8, stopped.
// - clearing control stops counter, internal clock, oscillator off, 1:1.
// - run-enable bit 0 starts counting; clearing it halts.
// - sync bypass bit lets the external clock count through sleep; its pin still passes the two-stage synchronizer.
// - synchronized external mode does not count in sleep; prescaler still does.
// - oscillator enable switches on the crystal oscillator, running in sleep.
// - asynchronous mode does not offer the count as capture/compare time base.
`timescale 1ns/1ps
module tcn_timer
    import tcn_pkg::*;
#(
    parameter int PS_WIDTH = 3
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        por_reset,
    input  wire logic        sleep,
    input  wire logic        ext_clk_in,
    input  wire logic        osc_clk_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq_req,
    output logic             wake_req,
    output logic             osc_run,
    output logic             time_base_valid,
    output logic      [15:0] time_base
);

    // ======================================================================
    // register state
    // ======================================================================
    tcn_ctrl_t   ctrl_q;
    logic [3:0]  irqc_q;
    logic [15:0] cmp_val_q;
    logic [3:0]  cmp_mode_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [PS_WIDTH-1:0] ps_q;
    logic        ext_s1_q;
    logic        ext_s2_q;
    logic        ext_prev_q;
    logic        osc_prev_q;
    logic        match_prev_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        irq_q;
    logic        wake_q;
    logic        osc_q;
    logic        tb_valid_q;

    function automatic logic [PS_WIDTH-1:0] ps_limit(input logic [1:0] sel);
        ps_limit = PS_WIDTH'((1 << sel) - 1);
    endfunction

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
        is_addr = (a == r);
    endfunction

    wire logic setup    = psel && !penable;
    wire logic acc      = psel && penable && pready_q;
    wire logic wr       = acc && pwrite;
    wire logic wr_low   = wr && is_addr(paddr, TCN_ADDR_LOW);
    wire logic wr_high  = wr && is_addr(paddr, TCN_ADDR_HIGH);
    wire logic wr_ctrl  = wr && is_addr(paddr, TCN_ADDR_CTRL);
    wire logic wr_irq   = wr && is_addr(paddr, TCN_ADDR_IRQ);
    wire logic wr_cmp   = wr && is_addr(paddr, TCN_ADDR_CMP);
    wire logic mapped   = is_addr(paddr, TCN_ADDR_LOW) || is_addr(paddr, TCN_ADDR_HIGH) ||
                          is_addr(paddr, TCN_ADDR_CTRL) || is_addr(paddr, TCN_ADDR_IRQ) ||
                          is_addr(paddr, TCN_ADDR_CMP);

    // ======================================================================
    // clock source selection
    // ======================================================================
    tcn_src_t src;
    always_comb begin
        if (!ctrl_q.clock_source_select) begin
            src = TCN_SRC_INT;
        end else if (ctrl_q.sync_bypass) begin
            src = TCN_SRC_ASYN;
        end else begin
            src = TCN_SRC_SYNC;
        end
    end

    // external pin is two-stage synchronised; the oscillator input is already on ref_clk
    always_ff @(posedge ref_clk) begin
        ext_s1_q   <= ext_clk_in;
        ext_s2_q   <= ext_s1_q;
        ext_prev_q <= ext_s2_q;
        osc_prev_q <= osc_clk_in;
    end

    wire logic ext_rise = ext_s2_q && !ext_prev_q;
    // oscillator pin only toggles while enabled, it runs through sleep
    wire logic osc_rise = ctrl_q.osc_en && osc_clk_in && !osc_prev_q;

    logic tick_raw;
    always_comb begin
        case (src)
            TCN_SRC_INT:  tick_raw = !sleep;
            TCN_SRC_SYNC: tick_raw = ext_rise;
            TCN_SRC_ASYN: tick_raw = osc_rise | ext_rise;
            default:      tick_raw = 1'b0;
        endcase
    end

    // ======================================================================
    // prescaler
    // ======================================================================
    wire logic ps_wrap = (ps_q == ps_limit(ctrl_q.prescale));

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ps_q <= '0;
        end else if (wr_low || wr_high) begin
            ps_q <= '0;
        end else if (ctrl_q.run_enable && tick_raw) begin
            ps_q <= ps_wrap ? '0 : ps_q + PS_WIDTH'(1);
        end
    end

    // sleep gates the synchronised path after the prescaler, never the async one
    wire logic adv = ctrl_q.run_enable && tick_raw && ps_wrap &&
                     !(sleep && src == TCN_SRC_SYNC);

    // ======================================================================
    // counter
    // ======================================================================
    wire logic special  = (cmp_mode_q == TCN_MODE_SPECIAL);
    wire logic match    = special && (count_q == cmp_val_q) && src != TCN_SRC_ASYN;
    wire logic trig     = match && !match_prev_q;
    wire logic overflow = adv && (count_q == TCN_CNT_ONES);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            match_prev_q <= 1'b0;
        end else begin
            match_prev_q <= match;
        end
    end

    always_comb begin
        count_d = count_q;
        if (wr_low) begin
            count_d = {count_q[15:8], pwdata[7:0]};
        end else if (wr_high) begin
            count_d = {pwdata[7:0], count_q[7:0]};
        end else if (trig) begin
            count_d = '0;
        end else if (adv) begin
            count_d = count_q + 16'h0001;
        end
    end

    // no reset term: the count survives every reset
    always_ff @(posedge ref_clk) begin
        count_q <= count_d;
    end

    // ======================================================================
    // control, compare and interrupt registers
    // ======================================================================
    always_ff @(posedge ref_clk) begin
        if (por_reset) begin
            ctrl_q <= tcn_ctrl_t'(TCN_CTL_RESET[5:0]);
        end else if (wr_ctrl) begin
            ctrl_q <= tcn_ctrl_t'(pwdata[5:0]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmp_val_q  <= '0;
            cmp_mode_q <= '0;
        end else if (wr_cmp) begin
            cmp_val_q  <= pwdata[15:0];
            cmp_mode_q <= pwdata[TCN_CMP_MODE_LSB +: 4];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irqc_q <= TCN_IRQ_RESET;
        end else begin
            if (wr_irq) begin
                irqc_q <= pwdata[3:0];
            end
            // hardware set beats a same-cycle software clear
            if (overflow) begin
                irqc_q[TCN_IRQ_FLAG] <= 1'b1;
            end
        end
    end

    wire logic irq_en = irqc_q[TCN_IRQ_FLAG] && irqc_q[TCN_IRQ_EN] &&
                        irqc_q[TCN_IRQ_PERIPHERAL_IRQ_ENABLE];

    // the core request also needs the global enable; the wake request does not,
    // so a sleeping core can still be woken while its interrupts are masked
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_en && irqc_q[TCN_IRQ_GIE];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= irq_en;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= ctrl_q.osc_en;
        end
    end

    // a count off an unsynchronised source would give capture and compare torn values
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tb_valid_q <= 1'b0;
        end else begin
            tb_valid_q <= (src != TCN_SRC_ASYN);
        end
    end

    // ======================================================================
    // apb slave: one wait state, answers at the second access cycle
    // ======================================================================
    wire logic first_acc = psel && penable && !pready_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= first_acc;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= first_acc && !mapped;
        end
    end

    // read data is cleared at each setup so a stale word never stands on the bus
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prdata_q <= '0;
        end else if (first_acc && !pwrite) begin
            case (paddr)
                TCN_ADDR_LOW:  prdata_q <= {24'h000000, count_q[7:0]};
                TCN_ADDR_HIGH: prdata_q <= {24'h000000, count_q[15:8]};
                TCN_ADDR_CTRL: prdata_q <= {24'h000000, {2'b00, ctrl_q} & TCN_CTL_MASK};
                TCN_ADDR_IRQ:  prdata_q <= {28'h0000000, irqc_q};
                TCN_ADDR_CMP:  prdata_q <= {12'h000, cmp_mode_q, cmp_val_q};
                default:       prdata_q <= '0;
            endcase
        end else if (setup) begin
            prdata_q <= '0;
        end
    end

    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign irq_req         = irq_q;
    assign wake_req        = wake_q;
    assign osc_run         = osc_q;
    assign time_base_valid = tb_valid_q;
    assign time_base       = count_q;

    // ======================================================================
    // checks
    // ======================================================================
    a_ovf_sets_flag: assert property (@(posedge ref_clk) disable iff (reset)
        overflow |=> irqc_q[TCN_IRQ_FLAG]) else $error("overflow did not set flag");

    a_trig_clears_cnt: assert property (@(posedge ref_clk) disable iff (reset)
        (trig && !wr_low && !wr_high) |=> count_q == 16'h0000) else $error("trigger did not clear count");

    a_trig_no_flag: assert property (@(posedge ref_clk) disable iff (reset)
        (trig && !irqc_q[TCN_IRQ_FLAG] && !wr_irq) |=> !irqc_q[TCN_IRQ_FLAG]) else $error("trigger set flag");

    a_write_wins: assert property (@(posedge ref_clk) disable iff (reset)
        (trig && wr_high) |=> count_q[15:8] == $past(pwdata[7:0])) else $error("write lost to trigger");

    a_ps_clear: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_low || wr_high) |=> ps_q == '0) else $error("prescaler not cleared");

    a_stop_holds: assert property (@(posedge ref_clk) disable iff (reset)
        (!ctrl_q.run_enable && !wr_low && !wr_high && !trig) |=> $stable(count_q))
        else $error("count moved while stopped");

    a_sync_sleep: assert property (@(posedge ref_clk) disable iff (reset)
        (sleep && src == TCN_SRC_SYNC) |-> !adv) else $error("sync count in sleep");

    a_irq_follows: assert property (@(posedge ref_clk) disable iff (reset)
        irq_en |=> wake_req) else $error("wake request missing");

    a_flag_sticky: assert property (@(posedge ref_clk) disable iff (reset)
        (irqc_q[TCN_IRQ_FLAG] && !wr_irq) |=> irqc_q[TCN_IRQ_FLAG]) else $error("flag dropped");

    a_ctrl_upper: assert property (@(posedge ref_clk) disable iff (reset)
        (pready_q && is_addr(paddr, TCN_ADDR_CTRL)) |-> prdata_q[7:6] == 2'b00) else $error("ctrl bits 7:6");

    a_async_tb: assert property (@(posedge ref_clk) disable iff (reset)
        (src == TCN_SRC_ASYN) |=> !time_base_valid) else $error("async time base offered");

    a_por_ctrl_clear: assert property (@(posedge ref_clk)
        por_reset |=> {2'b00, ctrl_q} == TCN_CTL_RESET) else $error("power on did not clear control");

    a_ctrl_kept: assert property (@(posedge ref_clk)
        (!por_reset && !wr_ctrl) |=> $stable(ctrl_q)) else $error("control changed without a write");

    a_count_kept: assert property (@(posedge ref_clk)
        (reset && !por_reset && !adv && !trig && !wr_low && !wr_high) |=> $stable(count_q))
        else $error("reset changed the count");

    a_ctrl_write: assert property (@(posedge ref_clk) disable iff (reset)
        (wr_ctrl && !por_reset) |=> {2'b00, ctrl_q} == ($past(pwdata[7:0]) & TCN_CTL_MASK))
        else $error("control write not applied");

    a_low_write: assert property (@(posedge ref_clk) disable iff (reset)
        wr_low |=> count_q[7:0] == $past(pwdata[7:0])) else $error("low byte write lost");

    a_wrap_zero: assert property (@(posedge ref_clk) disable iff (reset)
        (overflow && !wr_low && !wr_high && !trig) |=> count_q == 16'h0000) else $error("count did not wrap");

    a_async_sleep: assert property (@(posedge ref_clk) disable iff (reset)
        (sleep && src == TCN_SRC_ASYN && ctrl_q.run_enable && tick_raw && ps_wrap && !wr_low && !wr_high)
        |=> count_q == $past(count_q) + 16'h0001) else $error("async count stalled in sleep");

    a_sync_ps_sleep: assert property (@(posedge ref_clk) disable iff (reset)
        (sleep && src == TCN_SRC_SYNC && ctrl_q.run_enable && tick_raw && !ps_wrap && !wr_low && !wr_high)
        |=> ps_q == $past(ps_q) + PS_WIDTH'(1)) else $error("prescaler stalled in sleep");

    a_stop_ps: assert property (@(posedge ref_clk) disable iff (reset)
        (!ctrl_q.run_enable && !wr_low && !wr_high) |=> $stable(ps_q))
        else $error("prescaler moved while stopped");

    a_wake_gie: assert property (@(posedge ref_clk) disable iff (reset)
        irq_req |-> wake_req) else $error("request without wake");

    a_osc_follow: assert property (@(posedge ref_clk) disable iff (reset)
        ctrl_q.osc_en |=> osc_run) else $error("oscillator not running");

endmodule

//--- design/tcn_pkg.sv
package tcn_pkg;

    // ======================================================================
    // register map (word aligned byte addresses on the apb bus)
    // ======================================================================
    localparam logic [7:0] TCN_ADDR_LOW  = 8'h00;
    localparam logic [7:0] TCN_ADDR_HIGH = 8'h04;
    localparam logic [7:0] TCN_ADDR_CTRL = 8'h08;
    localparam logic [7:0] TCN_ADDR_IRQ  = 8'h0C;
    localparam logic [7:0] TCN_ADDR_CMP  = 8'h10;

    // ======================================================================
    // control register fields
    // ======================================================================
    localparam int         TCN_CTL_RUN     = 0;
    localparam int         TCN_CTL_CS      = 1;
    localparam int         TCN_CTL_SYNCB   = 2;
    localparam int         TCN_CTL_OSCEN   = 3;
    localparam int         TCN_CTL_PS_LO   = 4;
    localparam int         TCN_CTL_PS_HI   = 5;
    localparam logic [7:0] TCN_CTL_MASK    = 8'h3F;
    localparam logic [7:0] TCN_CTL_RESET   = 8'h00;

    // irq register fields: flag, enable, peripheral enable, global enable
    localparam int         TCN_IRQ_FLAG    = 0;
    localparam int         TCN_IRQ_EN      = 1;
    localparam int         TCN_IRQ_PERIPHERAL_IRQ_ENABLE    = 2;
    localparam int         TCN_IRQ_GIE     = 3;
    localparam logic [3:0] TCN_IRQ_RESET   = 4'h0;

    // compare register: value in bits 15:0, mode code in bits 19:16
    localparam int         TCN_CMP_MODE_LSB = 16;
    localparam logic [3:0] TCN_MODE_SPECIAL = 4'hB;

    localparam logic [2:0] TCN_PS_ONE      = 3'h1;
    localparam logic [15:0] TCN_CNT_ONES   = 16'hFFFF;

    typedef enum logic [1:0] {
        TCN_SRC_INT  = 2'b00,
        TCN_SRC_SYNC = 2'b01,
        TCN_SRC_ASYN = 2'b10
    } tcn_src_t;

    typedef struct packed {
        logic [1:0] prescale;
        logic       osc_en;
        logic       sync_bypass;
        logic       clock_source_select;
        logic       run_enable;
    } tcn_ctrl_t;

endpackage

//--- tb/tcn_clk_model.sv
`timescale 1ns/1ps
module tcn_clk_model #(
    parameter int HALF = 2
) (
    input  wire logic ref_clk,
    input  wire logic ext_on,
    input  wire logic osc_on,
    output logic      ext_clk_in,
    output logic      osc_clk_in
);
    int   cnt = 0;
    logic ph  = 1'b0;
    // ======================================================================
    // free running source, gated per pin
    // ======================================================================
    // the crystal ignores the core sleep state; only its enable stops it
    always @(posedge ref_clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        ph  <= (cnt == HALF - 1) ? ~ph : ph;
    end
    // a stopped source parks low, like a pin held by a pull-down
    assign ext_clk_in = ext_on & ph;
    assign osc_clk_in = osc_on & ph;
endmodule

//--- tb/test_timer_counter_16bit.sv
`timescale 1ns/1ps
module test_timer_counter_16bit;
    import tcn_pkg::*;
    logic        ref_clk, reset, por_reset, sleep, psel, penable, pwrite, clk_on, err;
    logic        pready, pslverr, irq_req, wake_req, osc_run, time_base_valid, ext_clk_in, osc_clk_in;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] time_base, t0, mx;
    int          failures, samples_checked;
    logic [7:0]  wv [5] = '{8'h30, 8'h32, 8'h3E, 8'hFF, 8'h00};
    logic [7:0]  ev [5] = '{8'h30, 8'h32, 8'h3E, 8'h3F, 8'h00};

    tcn_timer u_dut (.ref_clk(ref_clk), .reset(reset), .por_reset(por_reset), .sleep(sleep),
        .ext_clk_in(ext_clk_in), .osc_clk_in(osc_clk_in), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_req(irq_req), .wake_req(wake_req), .osc_run(osc_run),
        .time_base_valid(time_base_valid), .time_base(time_base));
    tcn_clk_model u_src (.ref_clk(ref_clk), .ext_on(clk_on), .osc_on(osc_run),
        .ext_clk_in(ext_clk_in), .osc_clk_in(osc_clk_in));

    // ======================================================================
    // shared tasks
    // ======================================================================
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one edge before setup so a release and a new request never share a time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask
    task automatic span(input int n);
        // let the edge that ends the last transfer settle before taking the start value
        @(posedge ref_clk);
        t0 = time_base;
        repeat (n) @(posedge ref_clk);
    endtask

    // ======================================================================
    // scenarios
    // ======================================================================
    task automatic t_reset();
        rdc("ctrl at power up", TCN_ADDR_CTRL, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, err});
        apb(1'b1, TCN_ADDR_CTRL, 32'h0000_0030);
        apb(1'b1, TCN_ADDR_LOW, 32'h0000_005A);
        apb(1'b1, TCN_ADDR_HIGH, 32'h0000_00A5);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        rdc("ctrl after reset", TCN_ADDR_CTRL, 32'h0000_0030);
        rdc("low byte after reset", TCN_ADDR_LOW, 32'h0000_005A);
        rdc("high byte after reset", TCN_ADDR_HIGH, 32'h0000_00A5);
        por_reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        por_reset <= 1'b0;
        rdc("ctrl after power on", TCN_ADDR_CTRL, 32'h0000_0000);
        rdc("count after power on", TCN_ADDR_HIGH, 32'h0000_00A5);
        $display("test reset done");
    endtask
    task automatic t_modes();
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, TCN_ADDR_CTRL, {24'h0, wv[i]});
            rdc("ctrl readback", TCN_ADDR_CTRL, {24'h0, ev[i]});
            chk("osc_run", {31'h0, ev[i][3]}, {31'h0, osc_run});
            chk("time base valid", {31'h0, ~(ev[i][2] & ev[i][1])}, {31'h0, time_base_valid});
        end
        $display("test modes done");
    endtask
    task automatic t_ovf();
        apb(1'b1, TCN_ADDR_LOW, 32'h0000_00F0);
        apb(1'b1, TCN_ADDR_HIGH, 32'h0000_00FF);
        apb(1'b1, TCN_ADDR_IRQ, 32'h0000_000E);
        apb(1'b1, TCN_ADDR_CTRL, 32'h0000_0001);
        for (int n = 0; n < 100 && irq_req !== 1'b1; n++) @(posedge ref_clk);
        chk("irq_req", 32'h1, {31'h0, irq_req});
        chk("wake_req", 32'h1, {31'h0, wake_req});
        chk("wrapped", 32'h1, {31'h0, time_base < 16'h0040});
        apb(1'b1, TCN_ADDR_CTRL, 32'h0000_0000);
        span(30);
        chk("stopped count", {16'h0, t0}, {16'h0, time_base});
        rdc("flag held", TCN_ADDR_IRQ, 32'h0000_000F);
        apb(1'b1, TCN_ADDR_IRQ, 32'h0000_0007);
        rdc("flag without global enable", TCN_ADDR_IRQ, 32'h0000_0007);
        chk("irq masked", 32'h0, {31'h0, irq_req});
        chk("wake unmasked", 32'h1, {31'h0, wake_req});
        apb(1'b1, TCN_ADDR_IRQ, 32'h0000_000E);
        rdc("flag cleared", TCN_ADDR_IRQ, 32'h0000_000E);
        chk("irq dropped", 32'h0, {31'h0, irq_req});
        chk("wake dropped", 32'h0, {31'h0, wake_req});
        $display("test overflow done");
    endtask
    task automatic t_presc();
        apb(1'b1, TCN_ADDR_CTRL, 32'h0000_0031);
        apb(1'b1, TCN_ADDR_HIGH, 32'h0000_0000);
        span(64);
        chk("ticks at 1:8", 32'd8, {16'h0, time_base - t0});
        $display("test prescale done");
    endtask
    task automatic t_trig();
        apb(1'b1, TCN_ADDR_CTRL, 32'h0000_0000);
        apb(1'b1, TCN_ADDR_LOW, 32'h0000_0000);
        apb(1'b1, TCN_ADDR_HIGH, 32'h0000_0000);
        apb(1'b1, TCN_ADDR_CMP, {12'h0, TCN_MODE_SPECIAL, 16'h0010});
        apb(1'b1, TCN_ADDR_CTRL, 32'h0000_0001);
        mx = 16'h0000;
        repeat (80) begin
            @(posedge ref_clk);
            mx = (time_base > mx) ? time_base : mx;
        end
        chk("period top", 32'h0000_0010, {16'h0, mx});
        rdc("no flag on trigger", TCN_ADDR_IRQ, 32'h0000_000E);
        // the high byte write lands on the edge at which the count first meets 3
        apb(1'b1, TCN_ADDR_CTRL, 32'h0000_0000);
        apb(1'b1, TCN_ADDR_LOW, 32'h0000_0000);
        apb(1'b1, TCN_ADDR_HIGH, 32'h0000_0000);
        apb(1'b1, TCN_ADDR_CMP, {12'h0, TCN_MODE_SPECIAL, 16'h0003});
        apb(1'b1, TCN_ADDR_CTRL, 32'h0000_0001);
        apb(1'b1, TCN_ADDR_HIGH, 32'h0000_0012);
        apb(1'b1, TCN_ADDR_CTRL, 32'h0000_0000);
        rdc("write beats trigger", TCN_ADDR_HIGH, 32'h0000_0012);
        apb(1'b1, TCN_ADDR_CMP, 32'h0000_0000);
        $display("test trigger done");
    endtask
    task automatic t_sleep();
        clk_on <= 1'b1;
        apb(1'b1, TCN_ADDR_CTRL, 32'h0000_0013);
        span(64);
        chk("sync counts awake", 32'h1, {31'h0, time_base != t0});
        sleep <= 1'b1;
        repeat (8) @(posedge ref_clk);
        span(64);
        chk("sync still asleep", {16'h0, t0}, {16'h0, time_base});
        apb(1'b1, TCN_ADDR_CTRL, 32'h0000_000F);
        span(64);
        chk("async counts asleep", 32'h1, {31'h0, time_base != t0});
        sleep <= 1'b0;
        clk_on <= 1'b0;
        $display("test sleep done");
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        wrap_up();
    end
    initial begin
        {reset, por_reset, sleep, psel, penable, pwrite, clk_on} = 7'b1100000;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        failures = 0;
        samples_checked = 0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        por_reset <= 1'b0;
        t_reset();
        t_modes();
        t_ovf();
        t_presc();
        t_trig();
        t_sleep();
        wrap_up();
    end
endmodule
